/* bench/pin_source.sv */
`timescale 1ns/10ps
// ***************************************
// field contacts on the channel pins
// ***************************************
module pin_source (
   // clock
   input  wire logic       clk_in,
   // pins, idle high as the pull-ups leave them
   output logic [7:0]      pins_out
);
   initial pins_out = 8'hff;

   // low pulses on the masked channels, gap equal to width keeps the rate down
   task automatic burst(input logic [7:0] m, input int w, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_in);
         pins_out <= pins_out & ~m;
         repeat (w) @(posedge clk_in);
         pins_out <= pins_out | m;
         repeat (w) @(posedge clk_in);
      end
   endtask

   // steady contact levels for state inputs
   task automatic level(input logic [7:0] v);
      @(posedge clk_in);
      pins_out <= v;
   endtask
endmodule // pin_source

/* bench/test_digital_input_counter.sv */
`timescale 1ns/10ps
module test_digital_input_counter
   import dic_pkg::*;
();
   // ***************************************
   // signals
   // ***************************************
   logic        clk = 1'b0, rst = 1'b1, fault = 1'b0;
   logic [1:0]  fsel = 2'b00;
   logic [7:0]  pins, awa = 8'h00, ara = 8'h00, led;
   logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [31:0] wd = 32'h0, rdat;
   logic [3:0]  wst = 4'hf;
   logic        awr, wrdy, bv, arr, rv, link, fled, irq;
   logic [1:0]  bresp, rresp;
   int          n_errors = 0, n_tests = 0;

   always #50 clk = ~clk;

   pin_source src (.clk_in(clk), .pins_out(pins));

   digital_input_counter #(.HS_CYC(2), .LS_CYC(12), .BLINK_CYC(8), .FLASH_CYC(8)) i_dut (
      .CLK_IN(clk), .RST_IN(rst), .CHAN_PIN_IN(pins), .FAST_SEL_IN(fsel), .FAULT_IN(fault),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(wst),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_BRESP(bresp),
      .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
      .LINK_ACT_LED_OUT(link), .INPUT_LED_OUT(led), .FAULT_LED_OUT(fled), .IRQ_OUT(irq));

   // ***************************************
   // compare, bus cycles, verdict
   // ***************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      awv <= 1'b1;
      wv  <= 1'b1;
      awa <= a;
      wd  <= d;
      bry <= 1'b1;
      // no cycle count assumed: only the watchdog ends a hung wait
      do begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrdy) wv <= 1'b0;
      end while (!(bry && bv));
      bry <= 1'b0;
      chk(bresp, er);
   endtask

   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      @(posedge clk);
      arv <= 1'b1;
      ara <= a;
      rry <= 1'b1;
      do begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
      end while (!(rry && rv));
      rry <= 1'b0;
      d = rdat;
      chk(rresp, er);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, RESP_OKAY, d);
      chk(d, e);
   endtask

   task automatic tally_and_finish();
      $display("comparisons=%0d mismatches=%0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // watchdog, far beyond the less than a thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      tally_and_finish();
   end

   // ***************************************
   // tests
   // ***************************************
   initial begin
      logic [31:0] b [3];
      logic [31:0] d;
      int          nh;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      // reset values and unmapped places
      rdc(OFS_MODE, RST_MODE);
      rdc(OFS_POL, RST_POL);
      rdc(OFS_IRQMSK, RST_MSK);
      rdc(OFS_STATE, 32'h0);
      rd(8'h18, RESP_SLVERR, d);
      chk(d, 32'h0);
      wr(8'h1c, 32'h1, RESP_SLVERR);
      // byte lane 0 disabled: the 8-bit mode register must keep its value
      wst <= 4'he;
      wr(OFS_MODE, 32'hff, RESP_OKAY);
      wst <= 4'hf;
      rdc(OFS_MODE, RST_MODE);
      // closed contact on channel 1, then inverted by polarity
      wr(OFS_IRQMSK, 32'h01, RESP_OKAY);
      src.level(8'hfe);
      repeat (40) @(posedge clk);
      rdc(OFS_STATE, 32'h01);
      chk(led, 8'h01);
      chk(irq, 1'b1);
      chk(link, 1'b1);
      rdc(OFS_IRQST, 32'h01);
      wr(OFS_POL, 32'h01, RESP_OKAY);
      repeat (4) @(posedge clk);
      rdc(OFS_STATE, 32'h0);
      chk(led, 8'h00);
      // a masked change flags status but leaves the interrupt low
      wr(OFS_IRQST, 32'hff, RESP_OKAY);
      src.level(8'hfc);
      repeat (40) @(posedge clk);
      chk(irq, 1'b0);
      rdc(OFS_IRQST, 32'h02);
      src.level(8'hff);
      wr(OFS_POL, 32'h00, RESP_OKAY);
      repeat (40) @(posedge clk);
      wr(OFS_IRQST, 32'hff, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      chk(link, 1'b0);
      // a poll blinks the link indicator for a bounded time
      wr(OFS_CTRL, 32'h04, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk(link, 1'b1);
      repeat (20) @(posedge clk);
      chk(link, 1'b0);
      // fault indicator: off, locate, then flashing on a module fault
      chk(fled, 1'b0);
      wr(OFS_CTRL, 32'h01, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk(fled, 1'b1);
      // remote fault bit alone holds the indicator steady
      wr(OFS_CTRL, 32'h02, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk(fled, 1'b1);
      rdc(OFS_CTRL, 32'h02);
      wr(OFS_CTRL, 32'h00, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk(fled, 1'b0);
      fault <= 1'b1;
      repeat (10) @(posedge clk);
      rdc(OFS_CTRL, 32'h04);
      nh = 0;
      for (int i = 0; i < 32; i++) begin
         @(posedge clk);
         if (fled === 1'b1) nh++;
      end
      chk(nh, 16);
      fault <= 1'b0;
      // counters: short pulses pass only the fast channel, long ones pass all
      wr(OFS_MODE, 32'h07, RESP_OKAY);
      for (int p = 0; p < 3; p++) begin
         fsel <= (p == 0) ? 2'b01 : (p == 1) ? 2'b10 : 2'b00;
         repeat (10) @(posedge clk);
         for (int i = 0; i < 3; i++) rd(OFS_CNT0 + 8'(4 * i), RESP_OKAY, b[i]);
         src.burst(8'h07, (p < 2) ? 6 : 30, (p < 2) ? 5 : 3);
         repeat (40) @(posedge clk);
         for (int i = 0; i < 3; i++) begin
            rdc(OFS_CNT0 + 8'(4 * i),
                b[i] + ((p < 2) ? ((i == p) ? 32'd5 : 32'd0) : 32'd3));
         end
      end
      tally_and_finish();
   end
endmodule // test_digital_input_counter

/* verilog/dic_pkg.sv */
package dic_pkg;

   // ***************************************
   // clock and timing
   // ***************************************
   localparam int CLK_HZ            = 10_000_000;
   localparam int CHAN_COUNT        = 8;
   // minimum pulse widths, as printed
   localparam int HS_WIDTH_US       = 50;
   localparam int LS_WIDTH_MS       = 50;
   // a filter needs the level to hold for part of the minimum width; use half
   localparam int HS_FILT_CYC       = (CLK_HZ / 1_000_000) * HS_WIDTH_US / 2;
   localparam int LS_FILT_CYC       = (CLK_HZ / 1_000) * LS_WIDTH_MS / 2;
   localparam int FILT_W            = 20;
   localparam int CNT_W             = 32;
   // link indicator stretch on a poll
   localparam int POLL_BLINK_CYC    = 50_000;
   // fault flash half period
   localparam int FAULT_FLASH_CYC   = 500_000;

   // ***************************************
   // register map (byte addresses)
   // ***************************************
   localparam logic [7:0] OFS_MODE   = 8'h00;  // 1 = counter per channel
   localparam logic [7:0] OFS_POL    = 8'h04;  // polarity invert
   localparam logic [7:0] OFS_STATE  = 8'h08;  // reported on/off
   localparam logic [7:0] OFS_IRQST  = 8'h0c;  // change flags, w1c
   localparam logic [7:0] OFS_IRQMSK = 8'h10;  // 1 = enabled
   localparam logic [7:0] OFS_CTRL   = 8'h14;  // bit0 locate, bit1 fault, bit2 poll on write, module fault on read
   localparam logic [7:0] OFS_CNT0   = 8'h20;  // counters at 0x20..0x3c

   localparam logic [31:0] RST_MODE  = 32'h0000_0000;
   localparam logic [31:0] RST_POL   = 32'h0000_0000;
   localparam logic [31:0] RST_MSK   = 32'h0000_0000;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic        locate;
      logic        fault;
   } status_ind_type;

endpackage

/* verilog/digital_input_counter.sv */
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module digital_input_counter
   import dic_pkg::*;
#(
   parameter int HS_CYC    = HS_FILT_CYC,
   parameter int LS_CYC    = LS_FILT_CYC,
   parameter int BLINK_CYC = POLL_BLINK_CYC,
   parameter int FLASH_CYC = FAULT_FLASH_CYC
) (
   // clock and reset
   input  wire logic        CLK_IN,
   input  wire logic        RST_IN,
   // input pins, one per channel
   input  wire logic [7:0]  CHAN_PIN_IN,
   // high speed selectors for channels 1 and 2, high = right position
   input  wire logic [1:0]  FAST_SEL_IN,
   // module fault condition from the board
   input  wire logic        FAULT_IN,
   // axi4-lite write address
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [7:0]  S_AXI_AWADDR,
   // axi4-lite write data
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   // axi4-lite write response
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   output logic [1:0]       S_AXI_BRESP,
   // axi4-lite read address
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   // axi4-lite read data
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   // indicators and interrupt
   output logic             LINK_ACT_LED_OUT,
   output logic [7:0]       INPUT_LED_OUT,
   output logic             FAULT_LED_OUT,
   output logic             IRQ_OUT
);

   // ***************************************
   // pin synchronisers
   // ***************************************
   logic [7:0] pin_m_q, pin_s_q;
   logic [1:0] sel_m_q, sel_s_q;
   logic       flt_m_q, flt_s_q;

   // two stages; first stage read only by the second
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         pin_m_q <= 8'hff;
         pin_s_q <= 8'hff;
         sel_m_q <= 2'h0;
         sel_s_q <= 2'h0;
         flt_m_q <= 1'b0;
         flt_s_q <= 1'b0;
      end else begin
         pin_m_q <= CHAN_PIN_IN;
         pin_s_q <= pin_m_q;
         sel_m_q <= FAST_SEL_IN;
         sel_s_q <= sel_m_q;
         flt_m_q <= FAULT_IN;
         flt_s_q <= flt_m_q;
      end
   end

   // ***************************************
   // channel front ends
   // ***************************************
   logic [7:0] fast;
   logic [7:0] level;
   logic [7:0] rise;
   logic [7:0] mode_q, mode_d;
   logic [7:0] pol_q, pol_d;

   // only channels 1 and 2 may run fast; the rest are held to 10 Hz filtering
   assign fast = {6'h00, sel_s_q};

   for (genvar g = 0; g < 8; g++) begin : g_chan
      pulse_filter #(
         .HS_CYC (HS_CYC),
         .LS_CYC (LS_CYC)
      ) u_filt (
         .CLK_IN    (CLK_IN),
         .RST_IN    (RST_IN),
         .active_in (~pin_s_q[g]),
         .fast_in   (fast[g]),
         .level_out (level[g]),
         .rise_out  (rise[g])
      );
   end

   // reported reading after the polarity attribute
   logic [7:0] report;
   assign report = level ^ pol_q;

   // ***************************************
   // totals
   // ***************************************
   logic [CNT_W-1:0] cnt_rd;
   logic [2:0]       cnt_idx_q, cnt_idx_d;

   // only counter channels accumulate
   pulse_counter #(
      .CH (CHAN_COUNT)
   ) u_cnt (
      .CLK_IN      (CLK_IN),
      .RST_IN      (RST_IN),
      .inc_in      (rise & mode_q),
      .rd_idx_in   (cnt_idx_d),  // index at the address edge, so the word is ready next cycle
      .rd_data_out (cnt_rd)
   );

   // ***************************************
   // change events
   // ***************************************
   logic [7:0] rep_q;
   logic [7:0] evt;
   logic [7:0] irq_st_q, irq_st_d;
   logic [7:0] irq_msk_q, irq_msk_d;

   // state channels flag a changed reading, counters flag each count
   assign evt = ((report ^ rep_q) & ~mode_q) | (rise & mode_q);

   // ***************************************
   // axi4-lite slave
   // ***************************************
   logic        aw_hold_q, aw_hold_d;
   logic        w_hold_q, w_hold_d;
   logic [7:0]  aw_addr_q, aw_addr_d;
   logic [31:0] w_data_q, w_data_d;
   logic [3:0]  w_strb_q, w_strb_d;
   logic        bvalid_q, bvalid_d;
   logic [1:0]  bresp_q, bresp_d;
   logic        rpend_q, rpend_d;
   logic        rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0]  rresp_q, rresp_d;
   logic [7:0]  ar_addr_q, ar_addr_d;
   logic [1:0]  ctrl_q, ctrl_d;
   logic        poll;
   logic        wr_go;
   logic [31:0] wmask;

   // merge one byte-enabled word into an 8-bit register
   function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      merge8 = s[0] ? d[7:0] : old;
   endfunction

   assign S_AXI_AWREADY = ~aw_hold_q & ~bvalid_q;
   assign S_AXI_WREADY  = ~w_hold_q & ~bvalid_q;
   assign S_AXI_ARREADY = ~rpend_q & ~rvalid_q;
   assign wr_go = aw_hold_q & w_hold_q;
   assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   // a write to the control poll bit stands for the controller checking the bus
   assign poll  = wr_go & (aw_addr_q == OFS_CTRL) & w_strb_q[0] & w_data_q[2];

   // write path and register updates
   always_comb begin
      aw_hold_d = aw_hold_q;
      w_hold_d  = w_hold_q;
      aw_addr_d = aw_addr_q;
      w_data_d  = w_data_q;
      w_strb_d  = w_strb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      mode_d    = mode_q;
      pol_d     = pol_q;
      irq_msk_d = irq_msk_q;
      ctrl_d    = ctrl_q;
      irq_st_d  = irq_st_q;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_hold_d = 1'b1;
         aw_addr_d = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_hold_d = 1'b1;
         w_data_d = S_AXI_WDATA;
         w_strb_d = S_AXI_WSTRB;
      end
      if (wr_go) begin
         aw_hold_d = 1'b0;
         w_hold_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = RESP_OKAY;
         case (aw_addr_q)
            OFS_MODE:   mode_d    = merge8(mode_q, w_data_q, w_strb_q);
            OFS_POL:    pol_d     = merge8(pol_q, w_data_q, w_strb_q);
            OFS_IRQMSK: irq_msk_d = merge8(irq_msk_q, w_data_q, w_strb_q);
            OFS_IRQST:  irq_st_d  = irq_st_q & ~(w_data_q[7:0] & wmask[7:0]);
            OFS_CTRL:   ctrl_d    = w_strb_q[0] ? w_data_q[1:0] : ctrl_q;
            OFS_STATE:  bresp_d   = RESP_OKAY;
            default:    bresp_d   = (aw_addr_q >= OFS_CNT0 && aw_addr_q[1:0] == 2'h0 &&
                                     aw_addr_q < OFS_CNT0 + 8'h20) ? RESP_OKAY : RESP_SLVERR;
         endcase
      end
      // a new event wins over a clear in the same cycle
      irq_st_d = irq_st_d | evt;
      if (bvalid_q && S_AXI_BREADY) begin
         bvalid_d = 1'b0;
      end
   end

   // read path: address taken, one cycle for the counter read, then data
   always_comb begin
      rpend_d   = rpend_q;
      rvalid_d  = rvalid_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      ar_addr_d = ar_addr_q;
      cnt_idx_d = cnt_idx_q;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         rpend_d   = 1'b1;
         ar_addr_d = S_AXI_ARADDR;
         cnt_idx_d = S_AXI_ARADDR[4:2];
      end
      if (rpend_q) begin
         rpend_d  = 1'b0;
         rvalid_d = 1'b1;
         rresp_d  = RESP_OKAY;
         case (ar_addr_q)
            OFS_MODE:   rdata_d = {24'h000000, mode_q};
            OFS_POL:    rdata_d = {24'h000000, pol_q};
            OFS_STATE:  rdata_d = {24'h000000, rep_q};
            OFS_IRQST:  rdata_d = {24'h000000, irq_st_q};
            OFS_IRQMSK: rdata_d = {24'h000000, irq_msk_q};
            OFS_CTRL:   rdata_d = {29'h00000000, flt_s_q, ctrl_q};
            default: begin
               if (ar_addr_q >= OFS_CNT0 && ar_addr_q < OFS_CNT0 + 8'h20 &&
                   ar_addr_q[1:0] == 2'h0) begin
                  rdata_d = cnt_rd;
               end else begin
                  rdata_d = 32'h00000000;
                  rresp_d = RESP_SLVERR;
               end
            end
         endcase
      end
      if (rvalid_q && S_AXI_RREADY) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h00000000;
         w_strb_q  <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         rpend_q   <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= RESP_OKAY;
         ar_addr_q <= 8'h00;
         cnt_idx_q <= 3'h0;
         mode_q    <= RST_MODE[7:0];
         pol_q     <= RST_POL[7:0];
         irq_msk_q <= RST_MSK[7:0];
         irq_st_q  <= 8'h00;
         ctrl_q    <= 2'h0;
         rep_q     <= 8'h00;
      end else begin
         aw_hold_q <= aw_hold_d;
         w_hold_q  <= w_hold_d;
         aw_addr_q <= aw_addr_d;
         w_data_q  <= w_data_d;
         w_strb_q  <= w_strb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rpend_q   <= rpend_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
         ar_addr_q <= ar_addr_d;
         cnt_idx_q <= cnt_idx_d;
         mode_q    <= mode_d;
         pol_q     <= pol_d;
         irq_msk_q <= irq_msk_d;
         irq_st_q  <= irq_st_d;
         ctrl_q    <= ctrl_d;
         rep_q     <= report;
      end
   end

   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP  = bresp_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA  = rdata_q;
   assign S_AXI_RRESP  = rresp_q;

   // ***************************************
   // indicators
   // ***************************************
   logic [19:0] blink_q, blink_d;
   logic [19:0] flash_q, flash_d;
   logic        flash_ph_q, flash_ph_d;
   logic        irq_q, led_act_q, led_flt_q;
   logic [7:0]  led_in_q;
   logic        irq_d, led_act_d, led_flt_d;
   status_ind_type ind;

   assign ind.locate = ctrl_q[0];
   assign ind.fault  = ctrl_q[1] | flt_s_q;

   // link lit while an event awaits the controller, stretched on a poll
   always_comb begin
      blink_d = (blink_q != 20'h00000) ? blink_q - 20'h00001 : 20'h00000;
      if (poll) begin
         blink_d = 20'(BLINK_CYC);
      end
      flash_d    = flash_q + 20'h00001;
      flash_ph_d = flash_ph_q;
      if (flash_q + 20'h00001 >= 20'(FLASH_CYC)) begin
         flash_d    = 20'h00000;
         flash_ph_d = ~flash_ph_q;
      end
      led_act_d = (irq_st_q != 8'h00) | (blink_q != 20'h00000);
      // input indicators are registered straight from the report below
      // hardware fault flashes fast; the remote fault bit is steady
      led_flt_d = ind.locate | (ind.fault & (ctrl_q[1] | flash_ph_q));
      irq_d     = |(irq_st_q & irq_msk_q);
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         blink_q    <= 20'h00000;
         flash_q    <= 20'h00000;
         flash_ph_q <= 1'b0;
         led_act_q  <= 1'b0;
         led_flt_q  <= 1'b0;
         led_in_q   <= 8'h00;
         irq_q      <= 1'b0;
      end else begin
         blink_q    <= blink_d;
         flash_q    <= flash_d;
         flash_ph_q <= flash_ph_d;
         led_act_q  <= led_act_d;
         led_flt_q  <= led_flt_d;
         led_in_q   <= report;
         irq_q      <= irq_d;
      end
   end

   assign LINK_ACT_LED_OUT = led_act_q;
   assign INPUT_LED_OUT    = led_in_q;
   assign FAULT_LED_OUT    = led_flt_q;
   assign IRQ_OUT          = irq_q;

   // ***************************************
   // checks
   // ***************************************
   chk_evt_sticky: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      |evt |=> (irq_st_q & $past(evt)) == $past(evt))
      else $error("event lost from status");
   chk_slow_chan: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      fast[7:2] == 6'h00)
      else $error("channel 3-8 in fast mode");
   chk_led_follow: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      ##1 INPUT_LED_OUT == $past(level ^ pol_q))
      else $error("input led does not follow reading");
   chk_state_quiet: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      ($stable(report) && rise == 8'h00) |=> (irq_st_q & ~$past(irq_st_q)) == 8'h00)
      else $error("status changed without event");
   chk_poll_blink: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      poll |-> ##2 LINK_ACT_LED_OUT)
      else $error("poll did not light link led");
   chk_locate_on: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      ctrl_q[0] |=> FAULT_LED_OUT)
      else $error("locate did not light fault led");
   chk_fault_off: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      (ctrl_q == 2'h0 && !flt_s_q) |=> !FAULT_LED_OUT)
      else $error("fault led on in normal operation");
   chk_state_nocount: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      |(rise & ~mode_q) |-> (evt & rise & ~mode_q) == 8'h00 || (report ^ rep_q) != 8'h00)
      else $error("state channel counted");

   cov_count: cover property (@(posedge CLK_IN) disable iff (RST_IN) |(rise & mode_q));
   cov_change: cover property (@(posedge CLK_IN) disable iff (RST_IN) |(report ^ rep_q));
   cov_irq: cover property (@(posedge CLK_IN) disable iff (RST_IN) IRQ_OUT);

endmodule // digital_input_counter

/* verilog/pulse_counter.sv */
`timescale 1ns/10ps
// ***************************************
// running totals, one word per channel
// ***************************************
module pulse_counter
   import dic_pkg::*;
#(
   parameter int CH = CHAN_COUNT
) (
   // clock and reset
   input  wire logic            CLK_IN,
   input  wire logic            RST_IN,
   // increments
   input  wire logic [CH-1:0]   inc_in,
   // read port
   input  wire logic [2:0]      rd_idx_in,
   output logic [CNT_W-1:0]     rd_data_out
);
   logic [CNT_W-1:0] tot_q [CH];
   logic [CNT_W-1:0] tot_d [CH];

   // totals wrap at full width
   always_comb begin
      for (int i = 0; i < CH; i++) begin
         tot_d[i] = inc_in[i] ? tot_q[i] + CNT_W'(1) : tot_q[i];
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         for (int i = 0; i < CH; i++) begin
            tot_q[i] <= '0;
         end
         rd_data_out <= '0;
      end else begin
         for (int i = 0; i < CH; i++) begin
            tot_q[i] <= tot_d[i];
         end
         rd_data_out <= tot_q[rd_idx_in];
      end
   end

endmodule // pulse_counter

/* verilog/pulse_filter.sv */
`timescale 1ns/10ps
// ***************************************
// per channel glitch filter and edge detect
// ***************************************
module pulse_filter
   import dic_pkg::*;
#(
   parameter int HS_CYC = HS_FILT_CYC,
   parameter int LS_CYC = LS_FILT_CYC
) (
   // clock and reset
   input  wire logic CLK_IN,
   input  wire logic RST_IN,
   // channel
   input  wire logic active_in,   // synchronised, active = on condition
   input  wire logic fast_in,     // high speed selected
   output logic      level_out,   // filtered on state
   output logic      rise_out     // one cycle, off to on
);
   logic [FILT_W-1:0] run_q, run_d;
   logic              lvl_q, lvl_d;
   logic [FILT_W-1:0] limit;

   // the width limit follows the speed mode
   always_comb begin
      limit = fast_in ? FILT_W'(HS_CYC) : FILT_W'(LS_CYC);
      run_d = run_q;
      lvl_d = lvl_q;
      if (active_in == lvl_q) begin
         run_d = '0;
      end else if (run_q + FILT_W'(1) >= limit) begin
         lvl_d = active_in;
         run_d = '0;
      end else begin
         run_d = run_q + FILT_W'(1);
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         run_q <= '0;
         lvl_q <= 1'b0;
      end else begin
         run_q <= run_d;
         lvl_q <= lvl_d;
      end
   end

   assign level_out = lvl_q;
   assign rise_out  = lvl_d & ~lvl_q;

   chk_short_ignored: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      $changed(lvl_q) |-> $past(run_q) + FILT_W'(1) >= $past(limit))
      else $error("filtered level changed before width reached");

endmodule // pulse_filter
